// *** bench/clk_sel_properties.sv ***
`timescale 1ns/10ps
module clk_sel_properties (
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       sel_wr,
  input wire logic [1:0] sel_wdata,
  input wire logic       halt_exec,
  input wire logic [1:0] clock_source_select,
  input wire logic       idle_on_halt_enable,
  input wire logic [1:0] active_source,
  input wire logic       clock_gate,
  input wire logic       osc_startup_done,
  input wire logic       secondary_osc_running,
  input wire logic       sleep_mode,
  input wire logic       idle_mode
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // select writes and switch timing
  a_sel_write_lands: assert property (sel_wr |=> clock_source_select == $past(sel_wdata))
    else $error("select field did not take the write");
  a_switch_behind_gate: assert property ($changed(active_source) |-> !$past(clock_gate))
    else $error("source changed with the gate open");
  // two old plus three new ticks can never fit in fewer than five cycles
  a_pause_min_len: assert property ($fell(clock_gate) |-> !clock_gate [*5])
    else $error("switch pause too short");
  a_pause_bounded: assert property ($fell(clock_gate) |-> ##[1:300] clock_gate)
    else $error("switch pause never ended");
  // status flags follow the real mux state
  a_flags_exclusive: assert property (!(osc_startup_done && secondary_osc_running))
    else $error("both status flags set");
  a_startup_flag_src: assert property (osc_startup_done |->
    active_source == 2'h2 && clock_gate)
    else $error("startup flag without primary source");
  a_sec_flag_src: assert property (secondary_osc_running |->
    active_source == 2'h1 && clock_gate)
    else $error("running flag without secondary source");
  // halt picks sleep or idle from the idle bit
  a_halt_mode_pick: assert property (halt_exec && !sleep_mode && !idle_mode
    && clock_source_select != 2'h1 |=> idle_mode == $past(idle_on_halt_enable)
    && sleep_mode == !$past(idle_on_halt_enable))
    else $error("halt entered the wrong mode");
  c_switch: cover property ($fell(clock_gate));
  c_primary: cover property (osc_startup_done);
  c_secondary: cover property (secondary_osc_running);
endmodule
bind system_clock_source_select clk_sel_properties chk_i (.clk_sys, .rst_b, .sel_wr, .sel_wdata,
  .halt_exec, .clock_source_select, .idle_on_halt_enable, .active_source, .clock_gate,
  .osc_startup_done, .secondary_osc_running, .sleep_mode, .idle_mode);

// *** bench/osc_sources.sv ***
`timescale 1ns/10ps
// free-running sources, unrelated in phase to clk_sys
module osc_sources (
  input  wire logic secondary_osc_enable,
  output logic      tick_internal,
  output logic      tick_secondary,
  output logic      tick_primary,
  output logic      startup_timer_done,
  output logic      internal_stable
);
  initial tick_internal = 1'b0;
  always #31 tick_internal = !tick_internal;
  // a disabled crystal gives no edges at all, so a refused switch could not finish
  initial tick_secondary = 1'b0;
  always #47 tick_secondary = secondary_osc_enable ? !tick_secondary : 1'b0;
  initial tick_primary = 1'b0;
  always #23 tick_primary = !tick_primary;
  // start-up timer expires during the first primary switch, before the handover
  initial begin
    internal_stable = 1'b0;
    startup_timer_done = 1'b0;
    #60 internal_stable = 1'b1;
    #240 startup_timer_done = 1'b1;
  end
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  import clk_sel_pkg::*;
  logic       clk_sys, rst_b = 1'b0, sel_wr = 1'b0, idle_wr = 1'b0, idle_wdata = 1'b0;
  logic       halt_exec = 1'b0, wake_event = 1'b0, default_source_choice = 1'b0;
  logic       secondary_osc_enable = 1'b1; // running from time zero; t_refuse clears it before its halt
  logic       startup_timer_done, internal_stable, tick_internal, tick_secondary;
  logic       tick_primary, idle_on_halt_enable, clock_gate, osc_startup_done;
  logic       secondary_osc_running, sleep_mode, idle_mode;
  logic [1:0] sel_wdata = 2'h0, clock_source_select, active_source, cur_src = 2'h0;
  logic [2:0] primary_osc_config = 3'h5, primary_mode;
  int         error_cnt = 0, comparisons = 0;

  system_clock_source_select dut (.clk_sys, .rst_b, .sel_wr, .sel_wdata, .idle_wr,
    .idle_wdata, .secondary_osc_enable, .primary_osc_config, .default_source_choice,
    .halt_exec, .wake_event, .startup_timer_done, .internal_stable, .tick_internal,
    .tick_secondary, .tick_primary, .clock_source_select, .idle_on_halt_enable,
    .active_source, .primary_mode, .clock_gate, .osc_startup_done,
    .secondary_osc_running, .sleep_mode, .idle_mode);
  osc_sources osc (.secondary_osc_enable, .tick_internal, .tick_secondary,
    .tick_primary, .startup_timer_done, .internal_stable);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = !clk_sys;
  end
  // inputs always move 1 ns after the edge
  task automatic step(int n = 1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(logic [3:0] seen, logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic write_sel(logic [1:0] v);
    sel_wdata = v;
    sel_wr = 1'b1;
    step();
    sel_wr = 1'b0;
  endtask
  task automatic t_reset();
    chk(clock_source_select, 4'h0);
    chk(active_source, 4'h0);
    chk({osc_startup_done, secondary_osc_running, clock_gate}, 4'h1);
    chk(primary_mode, 4'h5);
  endtask
  // one switch: field lands, old source holds, gate pauses, flags follow
  task automatic t_switch(logic [1:0] sel, logic dflt, logic [1:0] exp);
    int n;
    n = 0;
    default_source_choice = dflt;
    write_sel(sel);
    chk(clock_source_select, sel);
    chk(active_source, cur_src);
    while (clock_gate && n < 20) begin
      step();
      n++;
    end
    n = 0;
    while (!clock_gate && n < 300) begin
      step();
      n++;
    end
    chk(n >= 5 && n < 300, 4'h1);
    chk(active_source, exp);
    step(2);
    chk({osc_startup_done, secondary_osc_running}, {exp == SRC_PRIMARY,
      exp == SRC_SECONDARY});
    cur_src = exp;
  endtask
  task automatic t_refuse();
    secondary_osc_enable = 1'b0;
    step(5);
    write_sel(2'h1);
    step(80);
    chk({active_source, clock_gate}, 4'h1);
    halt_exec = 1'b1;
    step();
    halt_exec = 1'b0;
    step();
    chk({sleep_mode, idle_mode}, 4'h0);
    write_sel(2'h3);
    secondary_osc_enable = 1'b1;
    step(100);
  endtask
  task automatic t_halt(logic idle);
    idle_wdata = idle;
    idle_wr = 1'b1;
    step();
    idle_wr = 1'b0;
    chk(idle_on_halt_enable, idle);
    halt_exec = 1'b1;
    step();
    halt_exec = 1'b0;
    chk({sleep_mode, idle_mode}, {!idle, idle});
    wake_event = 1'b1;
    step();
    wake_event = 1'b0;
    step();
    chk({sleep_mode, idle_mode}, 4'h0);
  endtask
  // run should need about 400 cycles
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    step(10);
    rst_b = 1'b1;
    step(2);
    t_reset();
    primary_osc_config = 3'h2;
    t_switch(2'h2, 1'b0, 2'h2);
    t_switch(2'h1, 1'b0, 2'h1);
    t_switch(2'h3, 1'b0, 2'h0);
    t_switch(2'h0, 1'b1, 2'h2);
    t_switch(2'h1, 1'b1, 2'h1);
    t_switch(2'h0, 1'b0, 2'h0);
    t_refuse();
    t_halt(1'b0);
    t_halt(1'b1);
    chk(primary_mode, 4'h5);
    wrap_up();
  end
endmodule

// *** rtl/clk_sel_params.svh ***
`ifndef CLK_SEL_PARAMS_SVH
`define CLK_SEL_PARAMS_SVH
// Contract
// - two-bit select field chooses primary, secondary or internal oscillator
// - primary source comes from three-bit configuration setting, not select field
// - source changes only after a brief transition interval following a write
// - startup done bit (bit 3) set once timer expired and primary drives clock
// - secondary running bit (bit 6) set while secondary oscillator drives clock
// - startup done and secondary running never both set
// - both status bits clear means internal oscillator drives or is starting
// - halt enters sleep when idle enable clear, idle when set
// - secondary source selectable only while secondary enable bit (bit 3) set
// - halt with secondary selected but not enabled is ignored
// - select field cleared on every reset
// - select 00 uses internal if default choice clear, primary if set
// - switch pauses two old-source cycles plus three to four new-source cycles; code always waits exactly three new-source cycles
// - select 10 is primary, 01 is secondary
`define SEL_W             2
`define OSC_CFG_W         3
`define SEL_RESET         2'h0
`define STARTUP_DONE_BIT  3
`define SEC_RUNNING_BIT   6
`define SEC_ENABLE_BIT    3
`define OLD_CYCLES        3'h2
`define NEW_CYCLES_MIN    3'h3
`define NEW_CYCLES_MAX    3'h4
`endif

// *** rtl/clk_sel_pkg.sv ***
package clk_sel_pkg;
  typedef enum logic [1:0] {
    SRC_INTERNAL  = 2'b00,
    SRC_SECONDARY = 2'b01,
    SRC_PRIMARY   = 2'b10
  } src_t;
  typedef enum logic [1:0] {
    SW_RUN      = 2'b00,
    SW_OLD_WAIT = 2'b01,
    SW_NEW_WAIT = 2'b10
  } sw_state_t;
  typedef enum logic [1:0] {
    PM_RUN   = 2'b00,
    PM_SLEEP = 2'b01,
    PM_IDLE  = 2'b10
  } pm_t;
endpackage

// *** rtl/edge_sync.sv ***
`timescale 1ns/10ps
// two-stage synchroniser plus rising-edge pulse of an oscillator tick
module edge_sync (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic async_in,
  output logic      level,
  output logic      rise
);
  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;

  // meta feeds only the second stage
  always_comb begin
    next_meta = async_in;
    next_sync = meta;
    next_prev = sync;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  assign level = sync;
  assign rise  = sync & ~prev;
endmodule

// *** rtl/system_clock_source_select.sv ***
`timescale 1ns/10ps
`include "clk_sel_params.svh"
module system_clock_source_select
  import clk_sel_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  input  wire logic                  sel_wr,
  input  wire logic [`SEL_W-1:0]     sel_wdata,
  input  wire logic                  idle_wr,
  input  wire logic                  idle_wdata,
  input  wire logic                  secondary_osc_enable,
  input  wire logic [`OSC_CFG_W-1:0] primary_osc_config,
  input  wire logic                  default_source_choice,
  input  wire logic                  halt_exec,
  input  wire logic                  wake_event,
  input  wire logic                  startup_timer_done,
  input  wire logic                  internal_stable,
  input  wire logic                  tick_internal,
  input  wire logic                  tick_secondary,
  input  wire logic                  tick_primary,
  output logic [`SEL_W-1:0]          clock_source_select,
  output logic                       idle_on_halt_enable,
  output logic [1:0]                 active_source,
  output logic [`OSC_CFG_W-1:0]      primary_mode,
  output logic                       clock_gate,
  output logic                       osc_startup_done,
  output logic                       secondary_osc_running,
  output logic                       sleep_mode,
  output logic                       idle_mode
);

  // pin-side inputs pass two flops before any logic reads them
  logic tick_int_rise, tick_sec_rise, tick_pri_rise;
  logic sec_en_s, ost_s, int_stable_s;

  edge_sync u_tick_int (.clk_sys(clk_sys), .rst_b(rst_b), .async_in(tick_internal),
                        .level(), .rise(tick_int_rise));
  edge_sync u_tick_sec (.clk_sys(clk_sys), .rst_b(rst_b), .async_in(tick_secondary),
                        .level(), .rise(tick_sec_rise));
  edge_sync u_tick_pri (.clk_sys(clk_sys), .rst_b(rst_b), .async_in(tick_primary),
                        .level(), .rise(tick_pri_rise));
  edge_sync u_sec_en   (.clk_sys(clk_sys), .rst_b(rst_b), .async_in(secondary_osc_enable),
                        .level(sec_en_s), .rise());
  edge_sync u_ost      (.clk_sys(clk_sys), .rst_b(rst_b), .async_in(startup_timer_done),
                        .level(ost_s), .rise());
  edge_sync u_int_st   (.clk_sys(clk_sys), .rst_b(rst_b), .async_in(internal_stable),
                        .level(int_stable_s), .rise());

  // map a select value onto a physical source
  function automatic src_t decode_src(input logic [1:0] sel, input logic dflt);
    case (sel)
      2'b01:   decode_src = SRC_SECONDARY;
      2'b10:   decode_src = SRC_PRIMARY;
      2'b00:   decode_src = dflt ? SRC_PRIMARY : SRC_INTERNAL;
      default: decode_src = SRC_INTERNAL;
    endcase
  endfunction

  // tick of a given source, used for both old and new counts
  function automatic logic src_tick(input src_t s, input logic ti, input logic ts,
                                    input logic tp);
    case (s)
      SRC_SECONDARY: src_tick = ts;
      SRC_PRIMARY:   src_tick = tp;
      default:       src_tick = ti;
    endcase
  endfunction

  // control fields
  logic [1:0] sel_q, next_sel;
  logic       idle_q, next_idle;
  logic [2:0] cfg_q, next_cfg;
  logic       cfg_loaded, next_cfg_loaded;

  // configuration is latched once after reset release, not under reset
  always_comb begin
    next_sel        = sel_q;
    next_idle       = idle_q;
    next_cfg        = cfg_q;
    next_cfg_loaded = 1'b1;
    if (!cfg_loaded) begin
      next_cfg = primary_osc_config;
    end
    if (sel_wr) begin
      next_sel = sel_wdata;
    end
    if (idle_wr) begin
      next_idle = idle_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sel_q      <= `SEL_RESET;
      idle_q     <= 1'b0;
      cfg_q      <= 3'h0;
      cfg_loaded <= 1'b0;
    end else begin
      sel_q      <= next_sel;
      idle_q     <= next_idle;
      cfg_q      <= next_cfg;
      cfg_loaded <= next_cfg_loaded;
    end
  end

  // switch machine: glitch-free handover between sources
  sw_state_t  state, next_state;
  src_t       cur_src, next_cur_src;
  src_t       tgt_src, next_tgt_src;
  logic [2:0] cnt, next_cnt;
  logic       gate, next_gate;
  src_t       want_src;
  logic       sec_blocked;
  logic       old_tick, new_tick;

  // secondary is refused while its oscillator is disabled; hold current source
  always_comb begin
    want_src    = decode_src(sel_q, default_source_choice);
    sec_blocked = (want_src == SRC_SECONDARY) && !sec_en_s;
    old_tick    = src_tick(cur_src, tick_int_rise, tick_sec_rise, tick_pri_rise);
    new_tick    = src_tick(tgt_src, tick_int_rise, tick_sec_rise, tick_pri_rise);
  end

  always_comb begin
    next_state   = state;
    next_cur_src = cur_src;
    next_tgt_src = tgt_src;
    next_cnt     = cnt;
    next_gate    = gate;
    case (state)
      SW_RUN: begin
        // a change never takes effect in the same cycle as the write
        if (want_src != cur_src && !sec_blocked) begin
          next_tgt_src = want_src;
          next_cnt     = 3'h0;
          next_gate    = 1'b0;
          next_state   = SW_OLD_WAIT;
        end
      end
      SW_OLD_WAIT: begin
        if (old_tick) begin
          if (cnt == `OLD_CYCLES - 3'h1) begin
            next_cnt   = 3'h0;
            next_state = SW_NEW_WAIT;
          end else begin
            next_cnt = cnt + 3'h1;
          end
        end
      end
      SW_NEW_WAIT: begin
        // exactly three new-source edges; the NEW_CYCLES_MAX bound is never used
        if (new_tick) begin
          if (cnt == `NEW_CYCLES_MIN - 3'h1) begin
            next_cur_src = tgt_src;
            next_gate    = 1'b1;
            next_cnt     = 3'h0;
            next_state   = SW_RUN;
          end else begin
            next_cnt = cnt + 3'h1;
          end
        end
      end
      default: begin
        next_state = SW_RUN;
        next_gate  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state   <= SW_RUN;
      cur_src <= SRC_INTERNAL;   // internal runs until the first switch away completes
      tgt_src <= SRC_INTERNAL;
      cnt     <= 3'h0;
      gate    <= 1'b1;
    end else begin
      state   <= next_state;
      cur_src <= next_cur_src;
      tgt_src <= next_tgt_src;
      cnt     <= next_cnt;
      gate    <= next_gate;
    end
  end

  // power-managed mode on halt
  pm_t pm, next_pm;

  always_comb begin
    next_pm = pm;
    case (pm)
      PM_RUN: begin
        if (halt_exec && !sec_blocked) begin
          next_pm = idle_q ? PM_IDLE : PM_SLEEP;
        end
      end
      PM_SLEEP, PM_IDLE: begin
        if (wake_event) begin
          next_pm = PM_RUN;
        end
      end
      default: next_pm = PM_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pm <= PM_RUN;
    end else begin
      pm <= next_pm;
    end
  end

  // status derived from the multiplexer state and the start-up timer, never written by software
  logic next_ost_flag, next_sec_flag;

  always_comb begin
    // taken from the next mux state so a flag drops in the same cycle as the gate
    next_ost_flag = next_gate && (next_cur_src == SRC_PRIMARY) && ost_s;
    next_sec_flag = next_gate && (next_cur_src == SRC_SECONDARY);
    // the two are exclusive by source; internal clears both
    if (next_cur_src == SRC_INTERNAL) begin
      next_ost_flag = 1'b0;
      next_sec_flag = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      osc_startup_done      <= 1'b0;
      secondary_osc_running <= 1'b0;
      clock_source_select   <= `SEL_RESET;
      idle_on_halt_enable   <= 1'b0;
      active_source         <= 2'b00;
      primary_mode          <= 3'h0;
      clock_gate            <= 1'b1;
      sleep_mode            <= 1'b0;
      idle_mode             <= 1'b0;
    end else begin
      osc_startup_done      <= next_ost_flag;
      secondary_osc_running <= next_sec_flag;
      clock_source_select   <= next_sel;
      idle_on_halt_enable   <= next_idle;
      active_source         <= next_cur_src;
      primary_mode          <= next_cfg;
      clock_gate            <= next_gate;
      sleep_mode            <= (next_pm == PM_SLEEP);
      idle_mode             <= (next_pm == PM_IDLE);
    end
  end

  // internal stability is synchronised but read by no logic or output
  logic unused_ok;
  assign unused_ok = int_stable_s;
endmodule
